// file: verilog/sdp_pkg.sv
// Purpose: Shared constants and types for the serial debug port
//          read-only register block.
// Assumes: Seven-bit register addresses and eight-bit data on the link.
// Notes:   Every offset, field position and count lives here by name.
`default_nettype none

package sdp_pkg;

	// =====================================================================
	// Link framing.
	// =====================================================================
	localparam int unsigned ADDR_BITS = 7;
	localparam int unsigned DATA_BITS = 8;
	localparam int unsigned WAIT_LINK_CYCLES = 32;
	localparam logic [5:0] COUNT_ZERO = 6'h00;
	localparam logic [5:0] COUNT_ONE = 6'h01;
	localparam logic [5:0] COUNT_ADDR_LAST = 6'h07;
	localparam logic [5:0] COUNT_DATA_LAST = 6'h07;
	localparam logic DIR_READ = 1'b1;

	// =====================================================================
	// Register offsets in the read-only space.
	// =====================================================================
	localparam logic [6:0] ADDR_REVISION_CODE = 7'h02;
	localparam logic [6:0] ADDR_DEBUG_STATUS = 7'h03;
	localparam logic [6:0] ADDR_READBACK_LOW = 7'h10;
	localparam logic [6:0] ADDR_READBACK_HIGH = 7'h11;
	localparam logic [6:0] ADDR_READBACK_UPPER = 7'h12;
	localparam logic [6:0] ADDR_BUS_GRANT_STATUS = 7'h17;
	localparam logic [15:0] IO_ADDR_REVISION_CODE = 16'h0002;

	// =====================================================================
	// Field positions and reset values.
	// =====================================================================
	localparam int unsigned STAT_DEBUG_ACTIVE_BIT = 7;
	localparam int unsigned STAT_HALTED_BIT = 5;
	localparam int unsigned STAT_WIDE_ADDR_BIT = 4;
	localparam int unsigned STAT_MIXED_MEM_BIT = 3;
	localparam int unsigned STAT_IRQ_ENABLE_BIT = 2;
	localparam int unsigned BUS_ACCEPT_EN_BIT = 7;
	localparam int unsigned BUS_RELEASED_BIT = 6;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] NO_ANSWER_BYTE = 8'hff;
	localparam logic [23:0] READBACK_RESET = 24'h000000;

	// Live CPU state that feeds the debug status register.
	typedef struct packed {
		logic debugModeActive;
		logic cpuHaltedOrSleeping;
		logic wideAddressMode;
		logic mixedMemoryMode;
		logic interruptEnableFlag;
	} sdp_cpu_status_s;

	// Link-side frame states, one-hot.
	typedef enum logic [4:0] {
		LINK_IDLE = 5'h01,
		LINK_ADDR = 5'h02,
		LINK_WAIT = 5'h04,
		LINK_SEND = 5'h08,
		LINK_SKIP = 5'h10
	} sdp_link_state_e;

endpackage

`default_nettype wire

// file: verilog/sdp_sync.sv
// Purpose: Two flip-flop synchroniser for levels and toggles.
// Assumes: Each bit is an independent level or a toggle.
// Notes:   The first stage is read only by the second stage.
`default_nettype none

module sdp_sync
	import sdp_pkg::*;
#(
	parameter int unsigned WIDTH = 1
)
(
	input wire logic clock,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sdp_sync_state_s;

	sdp_sync_state_s state;
	sdp_sync_state_s next_state;

	// ====================================================================
	// Two stages; no reset, so the chain also carries reset itself.
	// ====================================================================
	always_comb
	begin
		next_state.stage1 = asyncIn;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clock)
	begin
		state <= next_state;
	end

	assign syncOut = state.stage2;

endmodule

`default_nettype wire

// file: verilog/sdp_readonly_regs.sv
// Purpose: Read-only register space of the serial debug port: revision,
//          live CPU status, 24-bit read-back value and bus grant status.
// Assumes: The link clock comes from the debug master and may stop
//          between frames; CPU status inputs are on the system clock.
// Notes:   A frame is a low start bit, seven address bits and a
//          direction bit (msb first), a fixed turnaround, then eight
//          data bits driven by the device on a read.
// Operation
// - The revision code reads at address 02h and also answers I/O 0002h.
// - Status bit 7 shows whether the CPU is in debug mode.
// - Status bit 5 shows whether the CPU is halted or asleep.
// - Status bit 4 shows wide address mode against compatible mode.
// - Status bit 3 mirrors the mixed memory mode bit.
// - Status bit 2 mirrors the maskable interrupt enable flag.
// - Status bits 6, 1 and 0 read zero and the register resets to zero.
// - The read-back value reads as bytes at 10h, 11h and 12h, reset zero.
// - With bus status bit 7 set, bus requests are granted after the op.
// - With bus status bit 7 clear, bus requests are ignored.
// - Bus status bit 6 reads one while the buses are released.
// - Bus status bits 5 to 0 read zero and the register resets to zero.
// - With instrumentation off the registers are reached over the link.
`default_nettype none

module sdp_readonly_regs
	import sdp_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value.
	parameter int unsigned TURNAROUND_CYCLES = WAIT_LINK_CYCLES
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic linkClock,
	input wire logic linkDataIn,
	output logic linkDataOut,
	output logic linkDataOutEnable,
	input wire logic instrumentationOff,
	input wire sdp_cpu_status_s cpuStatus,
	input wire logic [23:0] readbackValue,
	input wire logic readbackLoad,
	input wire logic [15:0] ioReadAddr,
	output logic [7:0] ioReadData,
	input wire logic busRequestAcceptEnable,
	input wire logic externalBusRequestN,
	output logic busAcknowledgeOutN
);

	// System-domain state.
	typedef struct packed {
		logic [23:0] readback;
		logic [7:0] respData;
		logic ackToggle;
		logic reqSeen;
		logic busesReleased;
		logic busAckN;
		logic [7:0] ioData;
	} sdp_sys_state_s;

	// Link-domain state.
	typedef struct packed {
		sdp_link_state_e mode;
		logic [5:0] count;
		logic [7:0] shift;
		logic [6:0] reqAddr;
		logic reqToggle;
		logic busy;
		logic dataOut;
		logic dataOutEnable;
	} sdp_link_state_s;

	sdp_sys_state_s sys;
	sdp_sys_state_s next_sys;
	sdp_link_state_s link;
	sdp_link_state_s next_link;

	logic reqToggleSync;
	logic linkBusySync;
	logic busRequestN;
	logic ackToggleSync;
	logic linkEnableSync;
	logic linkReset;

	// ====================================================================
	// Crossings.
	// ====================================================================
	// Toggle request and busy level into the system domain; pin too.
	sdp_sync #(.WIDTH(3)) u_sync_sys
	(
		.clock(clock),
		.asyncIn({link.reqToggle, link.busy, externalBusRequestN}),
		.syncOut({reqToggleSync, linkBusySync, busRequestN})
	);

	// Answer toggle, enable level and reset into the link domain.
	sdp_sync #(.WIDTH(3)) u_sync_link
	(
		.clock(linkClock),
		.asyncIn({sys.ackToggle, instrumentationOff, reset}),
		.syncOut({ackToggleSync, linkEnableSync, linkReset})
	);

	// ====================================================================
	// Register decode.
	// ====================================================================
	// Builds the byte for one read-only address from live state.
	function automatic logic [7:0] readByte
	(
		input logic [6:0] addr,
		input sdp_cpu_status_s cpu,
		input logic [23:0] value,
		input logic acceptEn,
		input logic released
	);
		logic [7:0] result;
		result = BYTE_ZERO;
		unique case (addr)
			ADDR_REVISION_CODE: result = REVISION_CODE;
			ADDR_DEBUG_STATUS:
			begin
				// Reserved bits 6, 1 and 0 stay at the zero start.
				result[STAT_DEBUG_ACTIVE_BIT] = cpu.debugModeActive;
				result[STAT_HALTED_BIT] = cpu.cpuHaltedOrSleeping;
				result[STAT_WIDE_ADDR_BIT] = cpu.wideAddressMode;
				result[STAT_MIXED_MEM_BIT] = cpu.mixedMemoryMode;
				result[STAT_IRQ_ENABLE_BIT] = cpu.interruptEnableFlag;
			end
			ADDR_READBACK_LOW: result = value[7:0];
			ADDR_READBACK_HIGH: result = value[15:8];
			ADDR_READBACK_UPPER: result = value[23:16];
			ADDR_BUS_GRANT_STATUS:
			begin
				// Bits 5 to 0 stay zero.
				result[BUS_ACCEPT_EN_BIT] = acceptEn;
				result[BUS_RELEASED_BIT] = released;
			end
			default: result = BYTE_ZERO;
		endcase
		return result;
	endfunction

	// ====================================================================
	// System domain: answer requests, hold read-back, grant the bus.
	// ====================================================================
	// A request is serviced once per toggle; the answer byte is taken
	// from live inputs in that very cycle and then held still until the
	// next request, which keeps the word safe to sample on the far side.
	always_comb
	begin
		next_sys = sys;
		if (readbackLoad)
		begin
			next_sys.readback = readbackValue;
		end
		if (reqToggleSync != sys.reqSeen)
		begin
			next_sys.reqSeen = reqToggleSync;
			next_sys.respData = readByte(link.reqAddr, cpuStatus,
				sys.readback, busRequestAcceptEnable,
				sys.busesReleased);
			next_sys.ackToggle = ~sys.ackToggle;
		end
		// I/O space view of the revision code.
		if (ioReadAddr == IO_ADDR_REVISION_CODE)
		begin
			next_sys.ioData = REVISION_CODE;
		end
		else
		begin
			next_sys.ioData = BYTE_ZERO;
		end
		// Grant only between link frames, drop when disabled or released.
		if (!busRequestAcceptEnable)
		begin
			next_sys.busesReleased = 1'b0;
		end
		else if (!busRequestN && !linkBusySync)
		begin
			next_sys.busesReleased = 1'b1;
		end
		else if (busRequestN)
		begin
			next_sys.busesReleased = 1'b0;
		end
		next_sys.busAckN = ~next_sys.busesReleased;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sys.readback <= READBACK_RESET;
			sys.respData <= BYTE_ZERO;
			sys.ackToggle <= 1'b0;
			sys.reqSeen <= 1'b0;
			sys.busesReleased <= 1'b0;
			sys.busAckN <= 1'b1;
			sys.ioData <= BYTE_ZERO;
		end
		else
		begin
			sys <= next_sys;
		end
	end

	// ====================================================================
	// Link domain: frame receiver and answer shifter.
	// ====================================================================
	// The turnaround is a fixed count of link clocks so that the master
	// knows when data starts; if the answer has not crossed by then the
	// device shifts out all ones, which the master can spot.
	always_comb
	begin
		next_link = link;
		next_link.dataOutEnable = 1'b0;
		unique case (link.mode)
			LINK_IDLE:
			begin
				next_link.busy = 1'b0;
				if (linkEnableSync && !linkDataIn)
				begin
					next_link.mode = LINK_ADDR;
					next_link.count = COUNT_ZERO;
					next_link.busy = 1'b1;
				end
			end
			LINK_ADDR:
			begin
				next_link.shift = {link.shift[6:0], linkDataIn};
				next_link.count = link.count + COUNT_ONE;
				if (link.count == COUNT_ADDR_LAST)
				begin
					next_link.count = COUNT_ZERO;
					if (linkDataIn == DIR_READ)
					begin
						next_link.reqAddr = link.shift[6:0];
						next_link.reqToggle = ~link.reqToggle;
						next_link.mode = LINK_WAIT;
					end
					else
					begin
						next_link.mode = LINK_SKIP;
					end
				end
			end
			LINK_WAIT:
			begin
				next_link.count = link.count + COUNT_ONE;
				if (link.count == 6'(TURNAROUND_CYCLES - 1))
				begin
					next_link.count = COUNT_ZERO;
					next_link.mode = LINK_SEND;
					next_link.dataOutEnable = 1'b1;
					if (ackToggleSync == link.reqToggle)
					begin
						next_link.shift = sys.respData;
					end
					else
					begin
						next_link.shift = NO_ANSWER_BYTE;
					end
					next_link.dataOut = next_link.shift[7];
				end
			end
			LINK_SEND:
			begin
				next_link.count = link.count + COUNT_ONE;
				next_link.shift = {link.shift[6:0], 1'b0};
				next_link.dataOut = link.shift[6];
				next_link.dataOutEnable = 1'b1;
				if (link.count == COUNT_DATA_LAST)
				begin
					next_link.mode = LINK_IDLE;
					next_link.dataOutEnable = 1'b0;
					next_link.dataOut = 1'b0;
					next_link.busy = 1'b0;
				end
			end
			LINK_SKIP:
			begin
				// Write data belongs to the write-only space elsewhere.
				next_link.count = link.count + COUNT_ONE;
				if (link.count == COUNT_DATA_LAST)
				begin
					next_link.mode = LINK_IDLE;
					next_link.busy = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge linkClock)
	begin
		if (linkReset)
		begin
			link.mode <= LINK_IDLE;
			link.count <= COUNT_ZERO;
			link.shift <= BYTE_ZERO;
			link.reqAddr <= ADDR_REVISION_CODE;
			link.reqToggle <= 1'b0;
			link.busy <= 1'b0;
			link.dataOut <= 1'b0;
			link.dataOutEnable <= 1'b0;
		end
		else
		begin
			link <= next_link;
		end
	end

	// ====================================================================
	// Outputs, each straight from a flip-flop.
	// ====================================================================
	assign linkDataOut = link.dataOut;
	assign linkDataOutEnable = link.dataOutEnable;
	assign ioReadData = sys.ioData;
	assign busAcknowledgeOutN = sys.busAckN;

endmodule

`default_nettype wire

// file: dv/sdp_readonly_regs_sva.sv
// Purpose: Port-level checks for the read-only debug register block.
// Assumes: A link frame that delays a grant lasts under eight clocks.
// Notes:   Bound to every instance of the register block.
`default_nettype none

module sdp_readonly_regs_sva
	import sdp_pkg::*;
#(
	parameter logic [7:0] REVISION_CODE = 8'h01
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic linkClock,
	input wire logic linkDataIn,
	input wire logic linkDataOut,
	input wire logic linkDataOutEnable,
	input wire logic instrumentationOff,
	input wire sdp_cpu_status_s cpuStatus,
	input wire logic [23:0] readbackValue,
	input wire logic readbackLoad,
	input wire logic [15:0] ioReadAddr,
	input wire logic [7:0] ioReadData,
	input wire logic busRequestAcceptEnable,
	input wire logic externalBusRequestN,
	input wire logic busAcknowledgeOutN
);
	timeunit 1ns;
	timeprecision 100ps;

	// =================================================================
	// Bus grant and I/O mirror.
	// =================================================================
	// A fresh request held for eight clocks with the grant enabled.
	sequence reqHeld;
		$fell(externalBusRequestN) && busRequestAcceptEnable
		##1 (busRequestAcceptEnable && !externalBusRequestN) [*8];
	endsequence
	ackGrant_a: assert property (
		@(posedge clock) disable iff (reset) reqHeld |-> !busAcknowledgeOutN)
		else $error("bus request not granted");
	ackCause_a: assert property (
		@(posedge clock) disable iff (reset)
		$fell(busAcknowledgeOutN) |-> $past(busRequestAcceptEnable))
		else $error("grant without enable");
	ackIgnored_a: assert property (
		@(posedge clock) disable iff (reset)
		!busRequestAcceptEnable |=> busAcknowledgeOutN)
		else $error("grant while disabled");
	ackRelease_a: assert property (
		@(posedge clock) disable iff (reset)
		$rose(externalBusRequestN) |-> ##[1:4] busAcknowledgeOutN)
		else $error("buses kept after request ended");
	ioRevision_a: assert property (
		@(posedge clock) disable iff (reset)
		ioReadAddr == IO_ADDR_REVISION_CODE |=> ioReadData == REVISION_CODE)
		else $error("revision missing at io address");
	ioOther_a: assert property (
		@(posedge clock) disable iff (reset)
		ioReadAddr != IO_ADDR_REVISION_CODE |=> ioReadData == BYTE_ZERO)
		else $error("io data at wrong address");
	resetValues_a: assert property (
		@(posedge clock) disable iff (reset) $fell(reset) |->
		busAcknowledgeOutN && ioReadData == BYTE_ZERO && !linkDataOutEnable)
		else $error("outputs not at reset values");

	// =================================================================
	// Link pin.
	// =================================================================
	// The device drives exactly eight bit times per read answer.
	linkDriveWidth_a: assert property (
		@(posedge linkClock) disable iff (reset) $rose(linkDataOutEnable)
		|-> linkDataOutEnable [*8] ##1 !linkDataOutEnable)
		else $error("answer not eight bits long");
	linkQuiet_a: assert property (
		@(posedge clock) disable iff (reset)
		(!instrumentationOff) [*8] |-> !linkDataOutEnable)
		else $error("link driven while disabled");
endmodule

bind sdp_readonly_regs sdp_readonly_regs_sva #(
	.REVISION_CODE(REVISION_CODE)
) sdp_readonly_regs_sva_inst (
	.clock(clock),
	.reset(reset),
	.linkClock(linkClock),
	.linkDataIn(linkDataIn),
	.linkDataOut(linkDataOut),
	.linkDataOutEnable(linkDataOutEnable),
	.instrumentationOff(instrumentationOff),
	.cpuStatus(cpuStatus),
	.readbackValue(readbackValue),
	.readbackLoad(readbackLoad),
	.ioReadAddr(ioReadAddr),
	.ioReadData(ioReadData),
	.busRequestAcceptEnable(busRequestAcceptEnable),
	.externalBusRequestN(externalBusRequestN),
	.busAcknowledgeOutN(busAcknowledgeOutN)
);

`default_nettype wire

// file: dv/sdp_link_master.sv
// Purpose: Behavioural debug master on the two-wire link.
// Assumes: Data line has a pull-up; clock stands low between frames.
// Notes:   Reads are sampled just before the rise that ends each bit.
`default_nettype none

module sdp_link_master
	import sdp_pkg::*;
#(
	parameter int unsigned TURNAROUND = WAIT_LINK_CYCLES
)
(
	output logic linkClock,
	output logic masterData,
	output logic masterEnable,
	input wire logic linkWire
);
	timeunit 1ns;
	timeprecision 100ps;

	// =================================================================
	// Link cycles and frames.
	// =================================================================
	// Idle: pin released, clock still.
	initial
	begin
		linkClock = 1'b0;
		masterData = 1'b1;
		masterEnable = 1'b0;
	end

	// The clock runs only while a task asks for cycles, 6 ns each.
	task automatic ticks(input int n);
		repeat (n)
		begin
			#3 linkClock = 1'b1;
			#3 linkClock = 1'b0;
		end
	endtask

	// Start bit, address msb first, direction, wait, eight data bits.
	task automatic readReg(input logic [6:0] addr, output logic [7:0] data);
		logic [8:0] head;
		head = {1'b0, addr, DIR_READ};
		masterEnable = 1'b1;
		for (int i = 8; i >= 0; i--)
		begin
			masterData = head[i];
			ticks(1);
		end
		masterEnable = 1'b0;
		ticks(TURNAROUND);
		for (int i = 7; i >= 0; i--)
		begin
			data[i] = linkWire;
			ticks(1);
		end
		ticks(1);
	endtask

	// Write frame: the device has to let all eight data bits pass by.
	task automatic writeReg(input logic [6:0] addr, input logic [7:0] data);
		logic [16:0] frame;
		frame = {1'b0, addr, ~DIR_READ, data};
		masterEnable = 1'b1;
		for (int i = 16; i >= 0; i--)
		begin
			masterData = frame[i];
			ticks(1);
		end
		masterEnable = 1'b0;
		masterData = 1'b1;
	endtask
endmodule

`default_nettype wire

// file: dv/sdp_readonly_regs_tb_top.sv
// Purpose: Self-checking bench for the read-only debug registers.
// Assumes: One scenario raises a bus request in mid-frame on purpose.
// Notes:   Link reads go through the master model's tasks.
`default_nettype none

module sdp_readonly_regs_tb_top;
	import sdp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] REV = 8'h3c; // Arbitrary value.
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic linkClock, linkWire, masterData, masterEnable;
	logic linkDataOut, linkDataOutEnable;
	logic instrumentationOff = 1'b1;
	sdp_cpu_status_s cpuStatus = '0;
	logic [23:0] readbackValue = 24'h000000;
	logic readbackLoad = 1'b0;
	logic [15:0] ioReadAddr = 16'h0000;
	logic [7:0] ioReadData, got;
	logic busRequestAcceptEnable = 1'b0;
	logic externalBusRequestN = 1'b1;
	logic busAcknowledgeOutN;
	int failCount = 0;
	int compares = 0;

	// =================================================================
	// Clock, pin and instances.
	// =================================================================
	always #20 clock = ~clock;
	// Released pin floats high through the pull-up.
	assign linkWire = linkDataOutEnable ? linkDataOut :
		masterEnable ? masterData : 1'b1;

	sdp_readonly_regs #(.REVISION_CODE(REV)) sdp_readonly_regs_inst (
		.clock(clock), .reset(reset), .linkClock(linkClock),
		.linkDataIn(linkWire), .linkDataOut(linkDataOut),
		.linkDataOutEnable(linkDataOutEnable),
		.instrumentationOff(instrumentationOff), .cpuStatus(cpuStatus),
		.readbackValue(readbackValue), .readbackLoad(readbackLoad),
		.ioReadAddr(ioReadAddr), .ioReadData(ioReadData),
		.busRequestAcceptEnable(busRequestAcceptEnable),
		.externalBusRequestN(externalBusRequestN),
		.busAcknowledgeOutN(busAcknowledgeOutN));
	sdp_link_master sdp_link_master_inst (.linkClock(linkClock),
		.masterData(masterData), .masterEnable(masterEnable),
		.linkWire(linkWire));

	// =================================================================
	// Tasks.
	// =================================================================
	task automatic endSim;
		$display("compares %0d mismatches %0d", compares, failCount);
		if (failCount == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic compare8(input logic [7:0] act, input logic [7:0] exp);
		compares++;
		if (act !== exp)
		begin
			failCount++;
			$display("[FAIL] %0t got %h exp %h", $time, act, exp);
		end
	endtask

	task automatic check(input logic [6:0] addr, input logic [7:0] exp);
		sdp_link_master_inst.readReg(addr, got);
		compare8(got, exp);
	endtask

	// Drive one status pattern, then read it back over the link.
	task automatic statusCheck(input logic [4:0] src,
		input logic [7:0] exp);
		@(posedge clock);
		cpuStatus <= sdp_cpu_status_s'(src);
		check(ADDR_DEBUG_STATUS, exp);
	endtask

	// Bounded wait for the grant pin; running out ends the run.
	task automatic waitAck(input logic level);
		int n;
		n = 0;
		while (busAcknowledgeOutN !== level && n < 20)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		compare8({7'h00, busAcknowledgeOutN}, {7'h00, level});
		if (busAcknowledgeOutN !== level)
			endSim();
	endtask

	task automatic drive(input logic acceptEn, input logic reqN);
		@(posedge clock);
		busRequestAcceptEnable <= acceptEn;
		externalBusRequestN <= reqN;
	endtask

	// =================================================================
	// Main sequence.
	// =================================================================
	initial
	begin
		sdp_link_master_inst.ticks(8);
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		sdp_link_master_inst.ticks(8);
		check(ADDR_DEBUG_STATUS, BYTE_ZERO);
		for (int i = 0; i < 3; i++)
			check(ADDR_READBACK_LOW + 7'(i), BYTE_ZERO);
		check(ADDR_BUS_GRANT_STATUS, BYTE_ZERO);
		check(ADDR_REVISION_CODE, REV);
		check(7'h05, BYTE_ZERO);
		// A write frame of zeros must not be taken for start bits.
		sdp_link_master_inst.writeReg(ADDR_DEBUG_STATUS, 8'h00);
		check(ADDR_REVISION_CODE, REV);
		@(posedge clock);
		ioReadAddr <= IO_ADDR_REVISION_CODE;
		@(posedge clock);
		#1 compare8(ioReadData, REV);
		// Each status source alone, then all at once.
		statusCheck(5'h10, 8'h80);
		statusCheck(5'h08, 8'h20);
		statusCheck(5'h04, 8'h10);
		statusCheck(5'h02, 8'h08);
		statusCheck(5'h01, 8'h04);
		statusCheck(5'h1f, 8'hbc);
		// A new value counts only once it is loaded.
		@(posedge clock);
		readbackValue <= 24'ha5c35a;
		readbackLoad <= 1'b1;
		@(posedge clock);
		readbackLoad <= 1'b0;
		readbackValue <= 24'h123456;
		check(ADDR_READBACK_LOW, 8'h5a);
		check(ADDR_READBACK_HIGH, 8'hc3);
		check(ADDR_READBACK_UPPER, 8'ha5);
		drive(1'b0, 1'b0);
		repeat (10) @(posedge clock);
		waitAck(1'b1);
		check(ADDR_BUS_GRANT_STATUS, BYTE_ZERO);
		drive(1'b1, 1'b1);
		drive(1'b1, 1'b0);
		waitAck(1'b0);
		check(ADDR_BUS_GRANT_STATUS, 8'hc0);
		drive(1'b1, 1'b1);
		waitAck(1'b1);
		check(ADDR_BUS_GRANT_STATUS, 8'h80);
		// A request raised in mid-frame waits for the frame to end.
		@(posedge clock);
		fork
			check(ADDR_BUS_GRANT_STATUS, 8'h80);
			begin
				repeat (3) @(posedge clock);
				externalBusRequestN <= 1'b0;
			end
		join
		compare8({7'h00, busAcknowledgeOutN}, 8'h01);
		waitAck(1'b0);
		drive(1'b1, 1'b1);
		waitAck(1'b1);
		drive(1'b1, 1'b0);
		waitAck(1'b0);
		drive(1'b0, 1'b0);
		waitAck(1'b1);
		// Link disabled: nobody answers, the pull-up reads as ones.
		@(posedge clock);
		instrumentationOff <= 1'b0;
		repeat (10) @(posedge clock);
		sdp_link_master_inst.ticks(8);
		check(ADDR_REVISION_CODE, 8'hff);
		@(posedge clock);
		instrumentationOff <= 1'b1;
		sdp_link_master_inst.ticks(8);
		check(ADDR_REVISION_CODE, REV);
		endSim();
	end
endmodule

`default_nettype wire
